//--- ldsl_top.sv
/*
 LED driver serial load latch: 224-bit shift register, command check and
 218-bit settings latch with decoded field outputs.
 Assumes serial pins are synchronous to CLOCK_IN and the serial clock is
 far slower than CLOCK_IN, so each rising edge is seen once.
*/
`timescale 1ns/1ps
`default_nettype none
module ldsl_top #(
    parameter int SHIFT_WIDTH = ldsl_pkg::SHIFT_WIDTH,
    parameter int LATCH_WIDTH = ldsl_pkg::LATCH_WIDTH
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic SERIAL_CLOCK_PIN_IN,
    input wire logic SERIAL_IN_PIN_IN,
    output logic SERIAL_OUT_PIN_OUT,
    output logic [ldsl_pkg::GS_CHANNELS*ldsl_pkg::GS_WIDTH-1:0]
        GRAYSCALE_OUT,
    output logic [ldsl_pkg::BRIGHT_WIDTH-1:0] RED_BRIGHTNESS_OUT,
    output logic [ldsl_pkg::BRIGHT_WIDTH-1:0] GREEN_BRIGHTNESS_OUT,
    output logic [ldsl_pkg::BRIGHT_WIDTH-1:0] BLUE_BRIGHTNESS_OUT,
    output logic BLANK_OUT,
    output logic DISPLAY_REPEAT_OUT,
    output logic TIMING_RESET_OUT,
    output logic EXT_GRAYSCALE_CLOCK_OUT,
    output logic RISING_EDGE_SELECT_OUT
);
    localparam int CMD_LSB = SHIFT_WIDTH - ldsl_pkg::CMD_WIDTH;

    // ==========================================================
    // State
    typedef struct packed {
        logic serial_clock_last;
        logic [SHIFT_WIDTH-1:0] shifter;
        logic [LATCH_WIDTH-1:0] settings_data_latch;
    } ldsl_top_type;
    ldsl_top_type r;
    ldsl_top_type next_r;
    logic serial_edge;
    logic cmd_ok;
    ldsl_latch_if latch_if ();

    // Command decode, shared by the timer and the latch
    function automatic logic ldsl_is_write(input logic [SHIFT_WIDTH-1:0] s);
        return s[SHIFT_WIDTH-1:CMD_LSB] == ldsl_pkg::WRITE_CMD;
    endfunction : ldsl_is_write

    assign serial_edge = SERIAL_CLOCK_PIN_IN & ~r.serial_clock_last;
    assign cmd_ok = ldsl_is_write(r.shifter);

    // ==========================================================
    // Latch pulse timer
    ldsl_pulse_timer u_timer (
        .clock_in(CLOCK_IN),
        .rst_in(RST_IN),
        .edge_in(serial_edge),
        .cmd_ok_in(cmd_ok),
        .latch_if(latch_if.timer)
    );

    // ==========================================================
    // Shift and latch; the whole latch loads in one edge, never per field
    always_comb begin
        next_r = r;
        next_r.serial_clock_last = SERIAL_CLOCK_PIN_IN;
        if (serial_edge) begin
            next_r.shifter = {r.shifter[SHIFT_WIDTH-2:0],
                SERIAL_IN_PIN_IN};
        end
        // Command rechecked here so a stray pulse cannot load junk
        if (latch_if.latch_pulse && ldsl_is_write(r.shifter)) begin
            next_r.settings_data_latch =
                r.shifter[LATCH_WIDTH-1:0];
        end
    end

    // Shifter is never reset; only serial_clock_last and the blank bit are forced at reset
    always_ff @(posedge CLOCK_IN) begin
        r.shifter <= next_r.shifter;
        r.serial_clock_last <= next_r.serial_clock_last;
        r.settings_data_latch <= next_r.settings_data_latch;
        if (RST_IN) begin
            r.serial_clock_last <= 1'b0;
            r.settings_data_latch[ldsl_pkg::BLANK_BIT] <= 1'b1;
        end
    end

    // ==========================================================
    // Registered outputs, fed from the latch except serial out, which takes the shifter MSB
    always_ff @(posedge CLOCK_IN) begin
        SERIAL_OUT_PIN_OUT <= next_r.shifter[SHIFT_WIDTH-1];
        GRAYSCALE_OUT <= next_r.settings_data_latch[
            ldsl_pkg::GS_CHANNELS*ldsl_pkg::GS_WIDTH-1:0];
        RED_BRIGHTNESS_OUT <= next_r.settings_data_latch[
            ldsl_pkg::BRIGHT_RED_LSB +: ldsl_pkg::BRIGHT_WIDTH];
        GREEN_BRIGHTNESS_OUT <= next_r.settings_data_latch[
            ldsl_pkg::BRIGHT_GREEN_LSB +: ldsl_pkg::BRIGHT_WIDTH];
        BLUE_BRIGHTNESS_OUT <= next_r.settings_data_latch[
            ldsl_pkg::BRIGHT_BLUE_LSB +: ldsl_pkg::BRIGHT_WIDTH];
        BLANK_OUT <= next_r.settings_data_latch[ldsl_pkg::BLANK_BIT];
        DISPLAY_REPEAT_OUT <=
            next_r.settings_data_latch[ldsl_pkg::REPEAT_BIT];
        TIMING_RESET_OUT <=
            next_r.settings_data_latch[ldsl_pkg::TIMING_RESET_BIT];
        EXT_GRAYSCALE_CLOCK_OUT <=
            next_r.settings_data_latch[ldsl_pkg::EXT_CLOCK_BIT];
        RISING_EDGE_SELECT_OUT <=
            next_r.settings_data_latch[ldsl_pkg::EDGE_SELECT_BIT];
        if (RST_IN) begin
            BLANK_OUT <= 1'b1;
        end
    end
endmodule : ldsl_top
`default_nettype wire

//--- ldsl_pkg.sv
/*
 Package for the LED driver serial load latch: frame widths, command code,
 latch field layout and timing constants.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package ldsl_pkg;
    // ==========================================================
    // Frame and latch geometry
    localparam int SHIFT_WIDTH = 224;
    localparam int LATCH_WIDTH = 218;
    localparam int CMD_WIDTH = 6;
    localparam logic [5:0] WRITE_CMD = 6'h25;
    // ==========================================================
    // Latch field positions
    localparam int GS_WIDTH = 16;
    localparam int GS_CHANNELS = 12;
    localparam int BRIGHT_WIDTH = 7;
    localparam int BRIGHT_RED_LSB = 192;
    localparam int BRIGHT_GREEN_LSB = 199;
    localparam int BRIGHT_BLUE_LSB = 206;
    localparam int BLANK_BIT = 213;
    localparam int REPEAT_BIT = 214;
    localparam int TIMING_RESET_BIT = 215;
    localparam int EXT_CLOCK_BIT = 216;
    localparam int EDGE_SELECT_BIT = 217;
    // ==========================================================
    // Latch pulse timing: quiet time is this many edge intervals
    localparam int QUIET_MULT = 8;
    localparam int INTERVAL_WIDTH = 20;
    // Edge detector states, Gray coded
    typedef enum logic [1:0] {
        LDSL_IDLE = 2'b00,
        LDSL_SHIFTING = 2'b01,
        LDSL_WAITING = 2'b11
    } ldsl_state_type;
endpackage : ldsl_pkg
`default_nettype wire

//--- ldsl_latch_if.sv
/*
 Interface carrying a latch request from the frame timer to the latch.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface ldsl_latch_if;
    logic latch_pulse;
    modport timer (output latch_pulse);
    modport latch (input latch_pulse);
endinterface : ldsl_latch_if
`default_nettype wire

//--- ldsl_pulse_timer.sv
/*
 Internal latch pulse generator: measures the gap between serial clock
 rising edges and, on a write command, fires once the line has stayed quiet eight gaps long.
 Assumes the edge strobe is already synchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ldsl_pulse_timer #(
    parameter int INTERVAL_WIDTH = ldsl_pkg::INTERVAL_WIDTH
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic edge_in,
    input wire logic cmd_ok_in,
    ldsl_latch_if.timer latch_if
);
    typedef struct packed {
        ldsl_pkg::ldsl_state_type state;
        logic [INTERVAL_WIDTH-1:0] gap;
        logic [INTERVAL_WIDTH-1:0] count;
        logic pulse;
    } ldsl_timer_type;
    ldsl_timer_type r;
    ldsl_timer_type next_r;
    logic [INTERVAL_WIDTH+2:0] limit;
    // ==========================================================
    // Quiet-time watch; the counter saturates so a long stall cannot wrap into a short gap
    always_comb begin
        next_r = r;
        next_r.pulse = 1'b0;
        limit = {r.gap, 3'h0};
        if (r.count != '1) begin
            next_r.count = r.count + 1'b1;
        end
        case (r.state)
            ldsl_pkg::LDSL_IDLE: begin
                if (edge_in) begin
                    next_r.state = ldsl_pkg::LDSL_SHIFTING;
                    next_r.count = '0;
                end
            end
            ldsl_pkg::LDSL_SHIFTING: begin
                if (edge_in) begin
                    next_r.gap = r.count;
                    next_r.count = '0;
                    next_r.state = ldsl_pkg::LDSL_WAITING;
                end
            end
            ldsl_pkg::LDSL_WAITING: begin
                if (edge_in) begin
                    next_r.gap = r.count;
                    next_r.count = '0;
                end else if ({3'h0, r.count} >= limit) begin
                    next_r.pulse = cmd_ok_in;
                    next_r.state = ldsl_pkg::LDSL_IDLE;
                end
            end
            default: begin
                next_r.state = ldsl_pkg::LDSL_IDLE;
            end
        endcase
    end
    // State register
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign latch_if.latch_pulse = r.pulse;
endmodule : ldsl_pulse_timer
`default_nettype wire

//--- ldsl_host_model.sv
/* Host model: shifts 224-bit frames into the serial pins.
 Assumes the bench calls send_frame; lines idle between frames. */
`timescale 1ns/1ps
`default_nettype none
module ldsl_host_model (
    input wire logic clock_in,
    output var logic serial_clock_out,
    output var logic serial_data_out
);
    // =====
    // Serial clock stands low outside frames
    initial begin
        serial_clock_out = 1'b0;
        serial_data_out = 1'b0;
    end
    // Half period counts CLOCK cycles, two or more
    task automatic send_frame(input logic [5:0] cmd,
            input logic [217:0] data, input int half);
        logic [223:0] frame;
        frame = {cmd, data};
        for (int i = 223; i >= 0; i--) begin
            @(negedge clock_in);
            serial_data_out = frame[i];
            repeat (half) @(negedge clock_in);
            serial_clock_out = 1'b1;
            repeat (half) @(negedge clock_in);
            serial_clock_out = 1'b0;
        end
        // Data no longer valid: show the inverse, never the last bit
        serial_data_out = ~frame[0];
    endtask : send_frame
endmodule : ldsl_host_model
`default_nettype wire

//--- ldsl_top_chk.sv
/* Checker for ldsl_top, bound to its ports.
 Assumes serial clock high and low last two cycles or more. */
`timescale 1ns/1ps
`default_nettype none
module ldsl_top_chk #(
    parameter int SHIFT_WIDTH = 224,
    parameter int LATCH_WIDTH = 218
) (
    input wire logic CLOCK_IN,
    input wire logic RST_IN,
    input wire logic SERIAL_CLOCK_PIN_IN,
    input wire logic SERIAL_IN_PIN_IN,
    input wire logic SERIAL_OUT_PIN_OUT,
    input wire logic [191:0] GRAYSCALE_OUT,
    input wire logic [6:0] RED_BRIGHTNESS_OUT,
    input wire logic [6:0] GREEN_BRIGHTNESS_OUT,
    input wire logic [6:0] BLUE_BRIGHTNESS_OUT,
    input wire logic BLANK_OUT,
    input wire logic DISPLAY_REPEAT_OUT,
    input wire logic TIMING_RESET_OUT,
    input wire logic EXT_GRAYSCALE_CLOCK_OUT,
    input wire logic RISING_EDGE_SELECT_OUT
);
    // =====
    // Shadow shifter and edge timing
    logic [LATCH_WIDTH-1:0] latch_d;
    logic [SHIFT_WIDTH-1:0] shadow;
    logic sck_d;
    int cnt, quiet, gap;
    wire logic rise = SERIAL_CLOCK_PIN_IN && !sck_d;
    wire logic [LATCH_WIDTH-1:0] latch = {RISING_EDGE_SELECT_OUT,
        EXT_GRAYSCALE_CLOCK_OUT, TIMING_RESET_OUT, DISPLAY_REPEAT_OUT,
        BLANK_OUT, BLUE_BRIGHTNESS_OUT, GREEN_BRIGHTNESS_OUT,
        RED_BRIGHTNESS_OUT, GRAYSCALE_OUT};
    // Case inequality so unknown power-up contents count as no change
    wire logic lchg = latch !== latch_d;
    wire logic cmd = shadow[SHIFT_WIDTH-1 -: 6] == ldsl_pkg::WRITE_CMD;
    // Track the shifter and the gap between the last two edges
    always_ff @(posedge CLOCK_IN) begin
        latch_d <= latch;
        sck_d <= RST_IN ? 1'b0 : SERIAL_CLOCK_PIN_IN;
        quiet <= rise ? 0 : quiet + 1;
        shadow <= rise ? {shadow[SHIFT_WIDTH-2:0], SERIAL_IN_PIN_IN} : shadow;
        gap <= rise ? quiet + 1 : gap;
        cnt <= RST_IN ? 0 : cnt + int'(rise && cnt < SHIFT_WIDTH);
    end
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    a_out_on_edge: assert property ($changed(SERIAL_OUT_PIN_OUT) |->
        $past(rise)) else $error("serial out moved without edge");
    a_out_is_msb: assert property (cnt == SHIFT_WIDTH |->
        SERIAL_OUT_PIN_OUT == shadow[SHIFT_WIDTH-1]) else $error("bad msb");
    a_load_copies: assert property (lchg |->
        latch == shadow[LATCH_WIDTH-1:0]) else $error("latch not shifter");
    a_load_needs_cmd: assert property (lchg |-> cmd)
        else $error("latch loaded without command");
    a_quiet_first: assert property (rise |=> !lchg [*8])
        else $error("latch moved during shifting");
    a_pulse_in_time: assert property (cnt >= 2 && cmd &&
        quiet == 8 * gap + 6 |-> latch == shadow[LATCH_WIDTH-1:0])
        else $error("latch pulse late");
    a_blank_in_reset: assert property (disable iff (1'b0)
        RST_IN |=> BLANK_OUT) else $error("blank not set in reset");
    a_blank_after: assert property ($fell(RST_IN) |->
        BLANK_OUT ##1 BLANK_OUT) else $error("blank lost after reset");
    c_load: cover property (lchg);
    c_refused: cover property (cnt >= 2 && !cmd && quiet == 8 * gap + 6);
    c_reset: cover property (disable iff (1'b0) $fell(RST_IN));
endmodule : ldsl_top_chk
bind ldsl_top ldsl_top_chk #(.SHIFT_WIDTH(SHIFT_WIDTH),
    .LATCH_WIDTH(LATCH_WIDTH)) i_chk (.*);
`default_nettype wire

//--- tb.sv
/* Testbench for ldsl_top: table of frames, then one reset case.
 Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {
        logic [5:0] cmd;
        logic [217:0] data;
        int half;
    } ldsl_row_type;
    logic clock, rst, sck, sdi, sdo, blank, rep, tmr, ext, edg;
    logic [191:0] gs;
    logic [6:0] br, bg, bb;
    logic [217:0] expect_latch;
    int n_fail, n_compared;
    ldsl_row_type rows [4];
    wire logic [217:0] latch = {edg, ext, tmr, rep, blank, bb, bg, br, gs};
    ldsl_host_model i_host (.clock_in(clock), .serial_clock_out(sck),
        .serial_data_out(sdi));
    ldsl_top i_dut (.CLOCK_IN(clock), .RST_IN(rst),
        .SERIAL_CLOCK_PIN_IN(sck), .SERIAL_IN_PIN_IN(sdi),
        .SERIAL_OUT_PIN_OUT(sdo), .GRAYSCALE_OUT(gs),
        .RED_BRIGHTNESS_OUT(br), .GREEN_BRIGHTNESS_OUT(bg),
        .BLUE_BRIGHTNESS_OUT(bb), .BLANK_OUT(blank),
        .DISPLAY_REPEAT_OUT(rep), .TIMING_RESET_OUT(tmr),
        .EXT_GRAYSCALE_CLOCK_OUT(ext), .RISING_EDGE_SELECT_OUT(edg));
    // =====
    // Free-running 50 MHz clock
    always #10 clock = ~clock;
    // Case equality so an unknown never passes
    task automatic check(input string name, input logic [217:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // Single exit for the run
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // Settings go in with blank still set, outputs enabled afterwards
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        n_fail = 0;
        n_compared = 0;
        rows[0] = '{6'h25, {4'h5, 1'b1, {7{3'h5}}, {12{16'hA5C3}}}, 2};
        rows[1] = '{6'h24, {4'hF, 1'b0, {7{3'h2}}, {12{16'h1234}}}, 2};
        rows[2] = '{6'h25, {4'hA, 1'b0, {7{3'h6}}, {24{8'h5A}}}, 5};
        rows[3] = '{6'h35, {4'h3, 1'b1, {7{3'h1}}, {12{16'hFFFF}}}, 3};
        repeat (16) @(negedge clock);
        rst = 1'b0;
        expect_latch = rows[0].data;
        foreach (rows[i]) begin
            i_host.send_frame(rows[i].cmd, rows[i].data, rows[i].half);
            // Quiet time is eight measured edge gaps of 2*half cycles each
            repeat (16 * rows[i].half + 16) @(negedge clock);
            if (rows[i].cmd == 6'h25) expect_latch = rows[i].data;
            check("latch", expect_latch, latch);
            check("serial out", 218'(rows[i].cmd[5]), 218'(sdo));
            $display("row %0d done", i);
        end
        // Reset mid-run, then a frame right after release
        rst = 1'b1;
        repeat (16) @(negedge clock);
        check("blank", 218'(1'b1), 218'(blank));
        rst = 1'b0;
        i_host.send_frame(6'h25, rows[2].data, 2);
        repeat (48) @(negedge clock);
        check("latch", rows[2].data, latch);
        $display("reset test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
